/* File: core/wtpfdc_pkg.sv */
// constants, register map and carrier types of the transmitter control core
// assumes one 125 MHz clock; coil current arrives in mA from a same-clock converter
package wtpfdc_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int PID_PERIOD_US = 1000;
  localparam int PID_PERIOD_CYC = (CLK_HZ / 1_000_000) * PID_PERIOD_US;
  // frequencies in Hz
  localparam logic [17:0] FREQ_MIN_HZ = 18'h1C138;
  localparam logic [17:0] FREQ_PING_HZ = 18'h2AB98;
  localparam logic [17:0] FREQ_MAX_HZ = 18'h320C8;
  localparam logic [17:0] BAND1_HZ = 18'h222E0;
  localparam logic [17:0] BAND2_HZ = 18'h27100;
  localparam logic [17:0] BAND3_HZ = 18'h2BF20;
  // output scaling factor per band, in half-Hz
  localparam logic [3:0] SCALE_B0 = 4'h3;
  localparam logic [3:0] SCALE_B1 = 4'h4;
  localparam logic [3:0] SCALE_B2 = 4'h6;
  localparam logic [3:0] SCALE_B3 = 4'hA;
  // duty in units of 0.01 percent
  localparam logic [12:0] DUTY_HALF = 13'h1388;
  localparam logic [12:0] DUTY_MIN = 13'h03E8;
  localparam int DUTY_FULL_SCALE_MULT = 429497;
  // loop constants
  localparam int PROPORTIONAL_GAIN = 10;
  localparam int DERIVATIVE_GAIN = 0;
  localparam int INTEGRAL_GAIN_Q16 = 3277;
  localparam int INTEGRAL_GAIN_SHIFT = 16;
  localparam int INTEGRAL_TERM_LIMIT = 3000;
  localparam int INTEGRAL_ACC_LIMIT = INTEGRAL_TERM_LIMIT * 20;
  localparam int LOOP_OUTPUT_LIMIT = 20000;
  localparam int CTRL_ERR_SHIFT = 7;
  // phase increment per Hz, Q10
  localparam logic [15:0] DDS_MULT_Q10 = 16'h8970;
  localparam int DDS_SHIFT = 10;
  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FREQ = 8'h08;
  localparam logic [7:0] REG_DUTY = 8'h0C;
  localparam logic [7:0] REG_CURRENT = 8'h10;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;

  typedef enum logic [2:0] {ST_IDLE, ST_PING, ST_GAP, ST_XFER, ST_NORX} wtpfdc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wtpfdc_bus_t;

  typedef struct packed {
    logic valid;
    logic [7:0] header;
    logic [7:0] payload;
  } wtpfdc_msg_t;
endpackage

/* File: core/wtpfdc_top.sv */
// control core: coil selection, ping, frequency/duty loop and half-bridge drive
// assumes the message decoder and current converter run on clk_sys
//
// Added by the designer: the register offsets and the plain strobed port.
module wtpfdc_top
  import wtpfdc_pkg::*;
#(
  parameter int PID_TICK_CYC = PID_PERIOD_CYC,
  parameter int PING_WAIT_MS = 70,
  parameter int GAP_MS = 10,
  parameter logic [7:0] HDR_SIGNAL_STRENGTH = 8'h01,
  parameter logic [7:0] HDR_END_POWER = 8'h02,
  parameter logic [7:0] HDR_CONTROL_ERROR = 8'h03
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire wtpfdc_bus_t bus,
  output logic [31:0] rdata,
  input wire wtpfdc_msg_t msg,
  input wire logic sampleValid,
  input wire logic [11:0] coilCurrentMa,
  output logic coilSel,
  output logic powerOn,
  output logic gateHigh,
  output logic gateLow
);

  wtpfdc_state_t state_reg;
  logic enable_reg;
  logic restart_reg;
  logic noRx_reg;
  logic [16:0] tickCnt_reg;
  logic tick_reg;
  logic [7:0] waitCnt_reg;
  logic coil_reg;
  logic dutyMode_reg;
  logic [17:0] freq_reg;
  logic [12:0] duty_reg;
  logic [11:0] sample_reg;
  logic signed [13:0] target_reg;
  int iacc_reg;
  logic [31:0] phase_reg;
  logic [31:0] rdata_reg;
  logic gateHigh_reg;
  logic gateLow_reg;

  logic isStrength;
  logic isEnd;
  logic isCtrlErr;
  int err;
  int iaccNext;
  int pid;
  int freqCalc;
  int dutyCalc;
  logic [17:0] freq_next;
  logic [12:0] duty_next;
  logic dutyMode_next;
  logic [33:0] incProd;
  logic [31:0] dutyThr;
  logic signed [20:0] ceProd;

  function automatic int clampSym(input int v, input int lim);
    if (v > lim)
      return lim;
    else if (v < -lim)
      return -lim;
    return v;
  endfunction

  function automatic logic [3:0] bandScale(input logic [17:0] f);
    if (f < BAND1_HZ)
      return SCALE_B0;
    else if (f < BAND2_HZ)
      return SCALE_B1;
    else if (f < BAND3_HZ)
      return SCALE_B2;
    return SCALE_B3;
  endfunction

  // message decode
  assign isStrength = msg.valid && (msg.header == HDR_SIGNAL_STRENGTH) && (msg.payload != 8'h00);
  assign isEnd = msg.valid && (msg.header == HDR_END_POWER);
  assign isCtrlErr = msg.valid && (msg.header == HDR_CONTROL_ERROR);

  // loop iteration, one per tick
  always_comb
  begin
    err = int'(target_reg) - int'({1'b0, sample_reg});
    iaccNext = clampSym(iacc_reg + err, INTEGRAL_ACC_LIMIT);
    // derivative gain is zero, so no difference term is kept
    pid = clampSym(PROPORTIONAL_GAIN * err + ((iacc_reg * INTEGRAL_GAIN_Q16) >>> INTEGRAL_GAIN_SHIFT)
      + DERIVATIVE_GAIN * err, LOOP_OUTPUT_LIMIT);
    freqCalc = int'({1'b0, freq_reg}) - ((pid * int'({1'b0, bandScale(freq_reg)})) >>> 1);
    dutyCalc = int'({1'b0, duty_reg}) + pid;
    freq_next = freq_reg;
    duty_next = duty_reg;
    dutyMode_next = dutyMode_reg;
    if (!dutyMode_reg)
    begin
      if (freqCalc >= int'({1'b0, FREQ_MAX_HZ}))
      begin
        freq_next = FREQ_MAX_HZ;
        dutyMode_next = 1'b1;
      end
      else if (freqCalc <= int'({1'b0, FREQ_MIN_HZ}))
        freq_next = FREQ_MIN_HZ;
      else
        freq_next = freqCalc[17:0];
    end
    else
    begin
      if (dutyCalc >= int'({1'b0, DUTY_HALF}))
      begin
        duty_next = DUTY_HALF;
        dutyMode_next = 1'b0;
      end
      else if (dutyCalc <= int'({1'b0, DUTY_MIN}))
        duty_next = DUTY_MIN;
      else
        duty_next = dutyCalc[12:0];
    end
  end

  // loop period divider
  always_ff @(posedge clk_sys)
  begin
    if (rst || tickCnt_reg == 17'(PID_TICK_CYC - 1))
      tickCnt_reg <= 17'h00000;
    else
      tickCnt_reg <= tickCnt_reg + 17'h00001;
    tick_reg <= !rst && (tickCnt_reg == 17'(PID_TICK_CYC - 1));
  end

  // control register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      enable_reg <= 1'b0;
      restart_reg <= 1'b0;
    end
    else
    begin
      restart_reg <= bus.wr && bus.addr == REG_CTRL && bus.wdata[CTRL_RESTART_BIT];
      if (bus.wr && bus.addr == REG_CTRL)
        enable_reg <= bus.wdata[CTRL_ENABLE_BIT];
    end
  end

  // coil search and transfer sequence
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      coil_reg <= 1'b0;
      noRx_reg <= 1'b0;
      waitCnt_reg <= 8'h00;
    end
    else if (!enable_reg)
    begin
      state_reg <= ST_IDLE;
      waitCnt_reg <= 8'h00;
    end
    else
    begin
      if (tick_reg)
        waitCnt_reg <= waitCnt_reg + 8'h01;
      case (state_reg)
        ST_IDLE:
        begin
          coil_reg <= 1'b0;
          waitCnt_reg <= 8'h00;
          state_reg <= ST_PING;
        end
        ST_PING:
        begin
          if (isStrength)
            state_reg <= ST_XFER;
          else if (tick_reg && waitCnt_reg == 8'(PING_WAIT_MS - 1))
          begin
            waitCnt_reg <= 8'h00;
            if (coil_reg)
            begin
              noRx_reg <= 1'b1;
              state_reg <= ST_NORX;
            end
            else
              state_reg <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (tick_reg && waitCnt_reg == 8'(GAP_MS - 1))
          begin
            coil_reg <= 1'b1;
            waitCnt_reg <= 8'h00;
            state_reg <= ST_PING;
          end
        end
        ST_XFER:
        begin
          if (isEnd)
            state_reg <= ST_IDLE;
        end
        ST_NORX:
        begin
          if (restart_reg)
          begin
            noRx_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // feedback and target
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sample_reg <= 12'h000;
      target_reg <= 14'sh0000;
    end
    else
    begin
      if (sampleValid)
        sample_reg <= coilCurrentMa;
      if (state_reg != ST_XFER)
        target_reg <= signed'({2'b00, sample_reg});
      else if (isCtrlErr)
        target_reg <= signed'({2'b00, sample_reg}) + 14'(ceProd >>> CTRL_ERR_SHIFT);
    end
  end

  // requested current moves by the control error in 1/128 steps
  assign ceProd = signed'({1'b0, sample_reg}) * signed'(msg.payload);

  // controlled variables
  always_ff @(posedge clk_sys)
  begin
    if (rst || state_reg != ST_XFER)
    begin
      freq_reg <= FREQ_PING_HZ;
      duty_reg <= DUTY_HALF;
      dutyMode_reg <= 1'b0;
      iacc_reg <= 0;
    end
    else if (tick_reg)
    begin
      freq_reg <= freq_next;
      duty_reg <= duty_next;
      dutyMode_reg <= dutyMode_next;
      iacc_reg <= iaccNext;
    end
  end

  // phase accumulator drive; edges dither on 8 ns grid so average duty keeps fine resolution
  assign incProd = freq_reg * DDS_MULT_Q10;
  assign dutyThr = 32'(duty_reg * DUTY_FULL_SCALE_MULT);

  always_ff @(posedge clk_sys)
  begin
    if (rst || !powerOn)
      phase_reg <= 32'h00000000;
    else
      phase_reg <= phase_reg + {8'h00, incProd[DDS_SHIFT +: 24]};
  end

  // no dead time here; the gate driver must insert it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      gateHigh_reg <= 1'b0;
      gateLow_reg <= 1'b0;
      powerOn <= 1'b0;
      coilSel <= 1'b0;
    end
    else
    begin
      powerOn <= state_reg == ST_PING || state_reg == ST_XFER;
      coilSel <= coil_reg;
      gateHigh_reg <= powerOn && (phase_reg < dutyThr);
      gateLow_reg <= powerOn && !(phase_reg < dutyThr);
    end
  end

  assign gateHigh = gateHigh_reg;
  assign gateLow = gateLow_reg;

  // register reads, answer in the following cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst || !bus.rd)
      rdata_reg <= 32'h00000000;
    else
    begin
      case (bus.addr)
        REG_CTRL:
          rdata_reg <= {31'h00000000, enable_reg};
        REG_STATUS:
          rdata_reg <= {27'h0000000, state_reg == ST_XFER, noRx_reg, dutyMode_reg, coil_reg, powerOn};
        REG_FREQ:
          rdata_reg <= {14'h0000, freq_reg};
        REG_DUTY:
          rdata_reg <= {19'h00000, duty_reg};
        REG_CURRENT:
          rdata_reg <= {20'h00000, sample_reg};
        default:
          rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign rdata = rdata_reg;

endmodule // wtpfdc_top

/* File: testbench/wtpfdc_checker.sv */
// port checker for the transmitter control core
// assumes bind onto wtpfdc_top, one clock, sync reset
module wtpfdc_checker
  import wtpfdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire wtpfdc_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic coilSel,
  input wire logic powerOn,
  input wire logic gateHigh,
  input wire logic gateLow
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // gate pipeline lags powerOn, so its edges are skipped
  property p_gate_comp;
    powerOn && $past(powerOn) && $past(powerOn, 3) |-> gateHigh != gateLow;
  endproperty
  a_gate_comp: assert property (p_gate_comp) else $error("gates not complementary");
  property p_gate_off;
    !powerOn && !$past(powerOn) && !$past(powerOn, 2) && !$past(powerOn, 3) |-> !gateHigh && !gateLow;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate on without power");
  property p_rd_idle;
    !bus.rd |=> rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_unmapped;
    bus.rd && bus.addr == 8'h20 |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_coil_stat;
    bus.rd && bus.addr == REG_STATUS |=> rdata[1] == coilSel;
  endproperty
  a_coil_stat: assert property (p_coil_stat) else $error("status coil mismatch");
  property p_norx;
    // status snapshot leads the registered powerOn by one cycle
    bus.rd && bus.addr == REG_STATUS ##1 rdata[3] |-> !rdata[4] && !powerOn ##1 (!powerOn && !gateHigh && !gateLow);
  endproperty
  a_norx: assert property (p_norx) else $error("power on with no receiver");
  property p_coil_swap;
    // coilSel and powerOn leave the same edge, so look at power before it
    $rose(coilSel) |-> !$past(powerOn);
  endproperty
  a_coil_swap: assert property (p_coil_swap) else $error("coil switched under power");
  property p_freq_rng;
    bus.rd && bus.addr == REG_FREQ && powerOn |=> rdata inside {[32'h1C138:32'h320C8]};
  endproperty
  a_freq_rng: assert property (p_freq_rng) else $error("frequency out of range");
  property p_duty_rng;
    bus.rd && bus.addr == REG_DUTY && powerOn |=> rdata inside {[32'h3E8:32'h1388]};
  endproperty
  a_duty_rng: assert property (p_duty_rng) else $error("duty out of range");
  c_ping: cover property ($rose(powerOn));
  c_coil1: cover property ($rose(coilSel));
  c_duty_min: cover property (bus.rd && bus.addr == REG_DUTY ##1 rdata == 32'h3E8);
endmodule // wtpfdc_checker

/* File: testbench/wtpfdc_rx_model.sv */
// behavioural power receiver beside the coils
// assumes powerOn and coilSel from the core, link controls from the bench
module wtpfdc_rx_model
  import wtpfdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic powerOn,
  input wire logic coilSel,
  input wire logic present,
  input wire logic rxCoil,
  input wire logic [7:0] ceVal,
  input wire logic endReq,
  output wtpfdc_msg_t msg,
  output logic sampleValid,
  output logic [11:0] coilCurrentMa
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic linked = 1'b0;
  initial
  begin
    msg = '0;
    sampleValid = 1'b0;
    coilCurrentMa = 12'h000;
  end
  always @(posedge clk_sys)
  begin
    cnt <= powerOn ? cnt + 1 : 0;
    // idle bytes toggle so stale data never looks valid
    msg <= '{valid: 1'b0, header: ~msg.header, payload: ~msg.payload};
    sampleValid <= powerOn && cnt[2:0] == 3'h0;
    coilCurrentMa <= powerOn ? 12'h3E8 : 12'h000;
    if (!powerOn)
      linked <= 1'b0;
    else if (!linked && present && coilSel == rxCoil && cnt == 20)
    begin
      msg <= '{valid: 1'b1, header: 8'h01, payload: 8'h40};
      linked <= 1'b1;
    end
    else if (linked && endReq)
    begin
      msg <= '{valid: 1'b1, header: 8'h02, payload: 8'h00};
      linked <= 1'b0;
    end
    else if (linked && cnt[5:0] == 6'h0)
      msg <= '{valid: 1'b1, header: 8'h03, payload: ceVal};
  end
endmodule // wtpfdc_rx_model

/* File: testbench/wtpfdc_tb_top.sv */
// self-checking bench for the transmitter control core
// assumes the receiver model and the bound port checker
module wtpfdc_tb_top
  import wtpfdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic rst;
  wtpfdc_bus_t bus;
  logic [31:0] rdata;
  wtpfdc_msg_t msg;
  logic sampleValid;
  logic [11:0] coilCurrentMa;
  logic coilSel, powerOn, gateHigh, gateLow;
  logic present, rxCoil, endReq;
  logic [7:0] ceVal;
  int err_total;
  int num_checks;
  // short tick and timeouts keep the run small
  wtpfdc_top #(.PID_TICK_CYC(50), .PING_WAIT_MS(3), .GAP_MS(2)) uut (.clk_sys, .rst, .bus, .rdata, .msg,
    .sampleValid, .coilCurrentMa, .coilSel, .powerOn, .gateHigh, .gateLow);
  wtpfdc_rx_model rx (.clk_sys, .powerOn, .coilSel, .present, .rxCoil, .ceVal, .endReq, .msg, .sampleValid,
    .coilCurrentMa);
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded status poll; running out ends the run
  task automatic poll(input int b, input logic v);
    logic [31:0] d;
    for (int i = 0; i < 500; i++)
    begin
      rd(REG_STATUS, d);
      if (d[b] === v)
        return;
    end
    check(32'(d[b]), 32'(v));
    end_of_test();
  endtask
  task automatic t_norx();
    logic [31:0] d;
    rd(REG_STATUS, d);
    check(d, 32'h0);
    rd(8'h20, d);
    check(d, 32'h0);
    wr(REG_CTRL, 32'h1);
    poll(0, 1'b1);
    rd(REG_FREQ, d);
    check(d, 32'(FREQ_PING_HZ));
    rd(REG_DUTY, d);
    check(d, 32'(DUTY_HALF));
    check(32'(coilSel), 32'h0);
    poll(0, 1'b0);
    poll(0, 1'b1);
    check(32'(coilSel), 32'h1);
    poll(3, 1'b1);
    check(32'(powerOn), 32'h0);
    $display("test norx done");
  endtask
  task automatic t_loop();
    logic [31:0] d;
    present <= 1'b1;
    rxCoil <= 1'b1;
    wr(REG_CTRL, 32'h3);
    poll(4, 1'b1);
    check(32'(coilSel), 32'h1);
    rd(REG_CURRENT, d);
    check(d, 32'h3E8);
    repeat (200) @(posedge clk_sys);
    rd(REG_FREQ, d);
    check(d, 32'(FREQ_PING_HZ));
    ceVal <= 8'h10;
    repeat (200) @(posedge clk_sys);
    rd(REG_FREQ, d);
    check(32'(d < 32'(FREQ_PING_HZ)), 32'h1);
    ceVal <= 8'h80;
    poll(2, 1'b1);
    rd(REG_FREQ, d);
    check(d, 32'(FREQ_MAX_HZ));
    repeat (400) @(posedge clk_sys);
    rd(REG_DUTY, d);
    check(d, 32'(DUTY_MIN));
    ceVal <= 8'h7F;
    poll(2, 1'b0);
    rd(REG_DUTY, d);
    check(d, 32'(DUTY_HALF));
    $display("test loop done");
  endtask
  task automatic t_end();
    endReq <= 1'b1;
    @(posedge clk_sys);
    endReq <= 1'b0;
    poll(1, 1'b0);
    check(32'(coilSel), 32'h0);
    $display("test end done");
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    rst = 1'b1;
    bus = '0;
    present = 1'b0;
    rxCoil = 1'b0;
    endReq = 1'b0;
    ceVal = 8'h00;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_norx();
    t_loop();
    t_end();
    end_of_test();
  end
endmodule // wtpfdc_tb_top
bind wtpfdc_top wtpfdc_checker chk (.clk_sys, .rst, .bus, .rdata, .coilSel, .powerOn, .gateHigh, .gateLow);
